// >>> design/bfd_detector.sv
// Breaker flashover detector: both schemes, per-phase timers, alarms ORed over phases
// What this block does
// - Timers start only when open with current
// - Open: low diff voltage, or status inputs
// - Scheme 1: arms when thermal diff collapses; stays armed past the five-cycle window
// - Scheme 2: side voltage live before flashover
// - Current loss, close, trip or close stop timers
// - Pending timer expiry raises pending alarm bit
// - Failure timer expiry raises breaker fail bit
// - Delays 0..16383 cycles in quarter steps
// - Inputs programmed as an OR of mask-selected logic bits
// - Auto and manual close block both schemes
// - High diff threshold proves prior voltage across
// - Low diff threshold detects collapsed voltage
// - Live threshold must precede flashover condition
// - Selector: off, scheme 1, scheme 2, custom
// - Load current threshold compared each quarter
module bfd_detector #(
   parameter int unsigned QCYC_CLKS = bfd_pkg::QCYC_CLKS
) (
   input  wire logic                           SYS_CLK_I,
   input  wire logic                           RST_N_I,
   input  wire bfd_pkg::bfd_cfg_t              CFG_I,
   input  wire bfd_pkg::bfd_map_t              MAP_I,
   input  wire logic [bfd_pkg::LBIT_W-1:0]     LOGIC_BITS_I,
   input  wire bfd_pkg::bfd_meas_t [2:0]       MEAS_I,
   output logic      [2:0]                     PENDING_TIMER_OUT_O,
   output logic      [2:0]                     FAILURE_TIMER_OUT_O,
   output logic      [2:0]                     TIMER_RUN_O,
   output logic                                FLASH_PENDING_ALARM_O,
   output logic                                FLASH_BREAKER_FAIL_O
);
   localparam int unsigned TW = $clog2(QCYC_CLKS);
   localparam logic [TW-1:0] TICK_LAST = TW'(QCYC_CLKS - 1);
   localparam logic [bfd_pkg::WIN_W-1:0] WIN_LOAD =
      bfd_pkg::WIN_W'(bfd_pkg::THERM_WIN_QTR);

   // Programmed input: OR of the logic bits selected by a mask
   function automatic logic sel_bits(
      input logic [bfd_pkg::LBIT_W-1:0] bits,
      input logic [bfd_pkg::LBIT_W-1:0] mask
   );
      sel_bits = |(bits & mask);
   endfunction : sel_bits

   // Isolated inputs arrive asynchronously, so two flops first
   logic [bfd_pkg::LBIT_W-1:0] bits_meta;
   logic [bfd_pkg::LBIT_W-1:0] bits_sync;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bits_meta <= '0;
         bits_sync <= '0;
      end else begin
         bits_meta <= LOGIC_BITS_I;
         bits_sync <= bits_meta;
      end
   end

   // Quarter-cycle processing tick
   logic [TW-1:0] tick_cnt;
   logic [TW-1:0] next_tick_cnt;
   logic          tick;
   logic          next_tick;

   always_comb begin
      next_tick     = (tick_cnt == TICK_LAST);
      next_tick_cnt = next_tick ? '0 : tick_cnt + TW'(1);
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tick_cnt <= '0;
         tick     <= bfd_pkg::RST_BIT;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick     <= next_tick;
      end
   end

   // Per-phase element and supervision state
   logic [2:0] high_diff, next_high_diff;
   logic [2:0] low_open, next_low_open;
   logic [2:0] thermal, next_thermal;
   logic [2:0] live, next_live;
   logic [2:0] load_det, next_load_det;
   logic [2:0] high_seen, next_high_seen;
   logic [2:0] arm1, next_arm1;
   logic [2:0] live_seen, next_live_seen;
   logic [2:0] run, next_run;
   logic [2:0][bfd_pkg::WIN_W-1:0] win, next_win;
   logic [2:0] trip_in, status_closed, block;
   logic       close_any, use_s1, use_s2;
   logic [2:0] pend_done, fail_done;
   logic [2:0] next_pend_out, next_fail_out;
   logic       next_pend_alarm, next_fail_alarm;

   always_comb begin
      close_any = sel_bits(bits_sync, MAP_I.auto_close_in)
                | sel_bits(bits_sync, MAP_I.manual_close_in);
      use_s1 = (CFG_I.scheme == bfd_pkg::BFD_SCHEME1)
             || (CFG_I.scheme == bfd_pkg::BFD_CUSTOM);
      use_s2 = (CFG_I.scheme == bfd_pkg::BFD_SCHEME2)
             || (CFG_I.scheme == bfd_pkg::BFD_CUSTOM);
      next_high_diff = high_diff;
      next_low_open  = low_open;
      next_thermal   = thermal;
      next_live      = live;
      next_load_det  = load_det;
      next_high_seen = high_seen;
      next_arm1      = arm1;
      next_live_seen = live_seen;
      next_run       = run;
      next_win       = win;
      for (int p = 0; p < 3; p++) begin
         trip_in[p]       = sel_bits(bits_sync, MAP_I.trip_in[p]);
         status_closed[p] = sel_bits(bits_sync, MAP_I.status[p]);
         block[p] = trip_in[p] | close_any;
         if (tick) begin
            // Elements sampled once per quarter cycle
            next_high_diff[p] =
               MEAS_I[p].diff_volt >= CFG_I.high_diff_th;
            next_low_open[p] =
               MEAS_I[p].diff_volt <= CFG_I.low_diff_th;
            next_thermal[p] =
               MEAS_I[p].diff_volt >= CFG_I.thermal_th;
            next_live[p] =
               MEAS_I[p].side_volt >= CFG_I.live_th;
            next_load_det[p] =
               MEAS_I[p].current > CFG_I.load_th;
            // Collapse window: reloaded while above thermal level
            if (thermal[p]) begin
               next_win[p] = WIN_LOAD;
               next_high_seen[p] = high_seen[p] | high_diff[p];
               next_arm1[p] = 1'b0;
            end else if (win[p] != '0) begin
               next_win[p] = win[p] - bfd_pkg::WIN_W'(1);
               if (high_seen[p]) begin
                  next_arm1[p] = 1'b1;
               end
            end else begin
               next_high_seen[p] = 1'b0;
            end
            // Live must be seen before current flows
            if (!load_det[p]) begin
               next_live_seen[p] = live[p];
            end
            next_run[p] = load_det[p] && !block[p] && (
               (use_s1 && arm1[p] && low_open[p])
               || (use_s2 && live_seen[p] && !status_closed[p]));
         end
         // Trip, close and scheme off stop at once; current loss and closed status stop only at a tick
         if (block[p]) begin
            next_run[p]       = 1'b0;
            next_arm1[p]      = 1'b0;
            next_live_seen[p] = 1'b0;
         end
         if (CFG_I.scheme == bfd_pkg::BFD_OFF) begin
            next_run[p] = 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         high_diff <= '0;
         low_open  <= '0;
         thermal   <= '0;
         live      <= '0;
         load_det  <= '0;
         high_seen <= '0;
         arm1      <= '0;
         live_seen <= '0;
         run       <= '0;
         win       <= {3{bfd_pkg::RST_WIN}};
      end else begin
         high_diff <= next_high_diff;
         low_open  <= next_low_open;
         thermal   <= next_thermal;
         live      <= next_live;
         load_det  <= next_load_det;
         high_seen <= next_high_seen;
         arm1      <= next_arm1;
         live_seen <= next_live_seen;
         run       <= next_run;
         win       <= next_win;
      end
   end

   // Both timers share one start; delays are in quarter cycles
   for (genvar p = 0; p < 3; p++) begin : g_phase
      bfd_timer #(.W(bfd_pkg::DLY_W)) u_pend (
         .clk_i   (SYS_CLK_I),
         .rst_n_i (RST_N_I),
         .tick_i  (tick),
         .run_i   (run[p]),
         .delay_i (CFG_I.pending_delay),
         .done_o  (pend_done[p])
      );
      bfd_timer #(.W(bfd_pkg::DLY_W)) u_fail (
         .clk_i   (SYS_CLK_I),
         .rst_n_i (RST_N_I),
         .tick_i  (tick),
         .run_i   (run[p]),
         .delay_i (CFG_I.failure_delay),
         .done_o  (fail_done[p])
      );
   end

   // Timer output bits and alarm bits, all registered
   always_comb begin
      next_pend_out   = pend_done & run;
      next_fail_out   = fail_done & run;
      next_pend_alarm = |next_pend_out;
      next_fail_alarm = |next_fail_out;
   end

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PENDING_TIMER_OUT_O   <= '0;
         FAILURE_TIMER_OUT_O   <= '0;
         TIMER_RUN_O           <= '0;
         FLASH_PENDING_ALARM_O <= bfd_pkg::RST_BIT;
         FLASH_BREAKER_FAIL_O  <= bfd_pkg::RST_BIT;
      end else begin
         PENDING_TIMER_OUT_O   <= next_pend_out;
         FAILURE_TIMER_OUT_O   <= next_fail_out;
         TIMER_RUN_O           <= run;
         FLASH_PENDING_ALARM_O <= next_pend_alarm;
         FLASH_BREAKER_FAIL_O  <= next_fail_alarm;
      end
   end
endmodule : bfd_detector

// >>> design/bfd_pkg.sv
// Shared constants and carrier types for the breaker flashover detector
package bfd_pkg;
   // System clock and power frequency
   localparam int unsigned SYS_CLK_HZ     = 10_000_000;
   localparam int unsigned POWER_HZ       = 60;
   localparam int unsigned QTR_PER_CYCLE  = 4;
   // Quarter power cycle, rounded down to whole system clocks
   localparam int unsigned QCYC_CLKS      =
      SYS_CLK_HZ / (POWER_HZ * QTR_PER_CYCLE);
   // Thermal-threshold collapse window, in power cycles
   localparam int unsigned THERM_WIN_CYC  = 5;
   localparam int unsigned THERM_WIN_QTR  = THERM_WIN_CYC * QTR_PER_CYCLE;

   // Field widths
   localparam int unsigned VOLT_W  = 12;  // 0.1 V per step
   localparam int unsigned CURR_W  = 13;  // 0.01 A per step
   localparam int unsigned DLY_W   = 16;  // quarter cycles, 0..65532
   localparam int unsigned LBIT_W  = 16;  // internal logic bits
   localparam int unsigned WIN_W   = 5;

   // Threshold limits in steps
   localparam logic [VOLT_W-1:0] DIFF_TH_MIN = 12'h00A;  // 1.0 V
   localparam logic [VOLT_W-1:0] DIFF_TH_MAX = 12'h5DC;  // 150.0 V
   localparam logic [VOLT_W-1:0] LIVE_TH_MIN = 12'h064;  // 10.0 V
   localparam logic [VOLT_W-1:0] LIVE_TH_MAX = 12'h4B0;  // 120.0 V
   localparam logic [CURR_W-1:0] LOAD_TH_MIN = 13'h0001; // 0.01 A
   localparam logic [CURR_W-1:0] LOAD_TH_MAX = 13'h1194; // 45.00 A
   localparam logic [DLY_W-1:0]  DLY_MAX     = 16'hFFFC; // 16383 cycles

   // Reset values of the outputs and internal state
   localparam logic              RST_BIT     = 1'b0;
   localparam logic [WIN_W-1:0]  RST_WIN     = 5'h00;

   typedef enum logic [1:0] {
      BFD_OFF     = 2'b00,
      BFD_SCHEME1 = 2'b01,
      BFD_SCHEME2 = 2'b10,
      BFD_CUSTOM  = 2'b11
   } bfd_scheme_t;

   // Thresholds and delays
   typedef struct packed {
      bfd_scheme_t              scheme;
      logic [VOLT_W-1:0]        high_diff_th;
      logic [VOLT_W-1:0]        low_diff_th;
      logic [VOLT_W-1:0]        thermal_th;
      logic [VOLT_W-1:0]        live_th;
      logic [CURR_W-1:0]        load_th;
      logic [DLY_W-1:0]         pending_delay;
      logic [DLY_W-1:0]         failure_delay;
   } bfd_cfg_t;

   // Selection masks: each input is the OR of the selected logic bits
   typedef struct packed {
      logic [2:0][LBIT_W-1:0]   trip_in;
      logic [2:0][LBIT_W-1:0]   status;
      logic [LBIT_W-1:0]        auto_close_in;
      logic [LBIT_W-1:0]        manual_close_in;
   } bfd_map_t;

   // Per-phase measurements
   typedef struct packed {
      logic [VOLT_W-1:0]        diff_volt;
      logic [VOLT_W-1:0]        side_volt;
      logic [CURR_W-1:0]        current;
   } bfd_meas_t;
endpackage : bfd_pkg

// >>> design/bfd_timer.sv
// Pickup timer advancing once per quarter cycle, cleared when not run
module bfd_timer #(
   parameter int unsigned W = bfd_pkg::DLY_W
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         tick_i,
   input  wire logic         run_i,
   input  wire logic [W-1:0] delay_i,
   output logic              done_o
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic         next_done;

   always_comb begin
      next_count = count;
      if (!run_i) begin
         next_count = '0;
      end else if (tick_i && (count != {W{1'b1}})) begin
         next_count = count + W'(1);
      end
      next_done = run_i && (next_count >= delay_i);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count  <= '0;
         done_o <= bfd_pkg::RST_BIT;
      end else begin
         count  <= next_count;
         done_o <= next_done;
      end
   end
endmodule : bfd_timer

// >>> dv/bfd_breaker_model.sv
// Breaker contacts and trip and close command sources
module bfd_breaker_model (
   input  wire logic        clk_i,
   input  wire logic [2:0]  pole_closed_i,
   input  wire logic [2:0]  trip_i,
   input  wire logic [1:0]  close_i,
   output logic      [15:0] bits_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Bits 0-2 contacts, 3-5 trips, 6 auto close, 7 manual close
   // Pending alarm is never routed back onto the trip bits
   always @(posedge clk_i) begin
      bits_o <= {8'h00, close_i, trip_i, pole_closed_i};
   end
endmodule : bfd_breaker_model

// >>> dv/bfd_detector_properties.sv
// Output checker for the breaker flashover detector
module bfd_checker #(
   parameter int unsigned QCYC_CLKS = 4
) (
   input wire logic                        SYS_CLK_I,
   input wire logic                        RST_N_I,
   input wire bfd_pkg::bfd_cfg_t           CFG_I,
   input wire bfd_pkg::bfd_map_t           MAP_I,
   input wire logic [bfd_pkg::LBIT_W-1:0]  LOGIC_BITS_I,
   input wire bfd_pkg::bfd_meas_t [2:0]    MEAS_I,
   input wire logic [2:0]                  PENDING_TIMER_OUT_O,
   input wire logic [2:0]                  FAILURE_TIMER_OUT_O,
   input wire logic [2:0]                  TIMER_RUN_O,
   input wire logic                        FLASH_PENDING_ALARM_O,
   input wire logic                        FLASH_BREAKER_FAIL_O
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] idle_cnt;
   logic [7:0] next_idle_cnt;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Three ticks cover element sampling plus the run register
   always_comb begin
      next_idle_cnt = 8'h00;
      if (MEAS_I[0].current <= CFG_I.load_th) begin
         next_idle_cnt = (idle_cnt == 8'hFF) ? idle_cnt : idle_cnt + 8'h01;
      end
   end
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         idle_cnt <= 8'h00;
      end else begin
         idle_cnt <= next_idle_cnt;
      end
   end
   chk_pend_alarm:
   assert property (FLASH_PENDING_ALARM_O == (|PENDING_TIMER_OUT_O))
      else $error("Pending alarm differs from timer outputs");
   chk_fail_alarm:
   assert property (FLASH_BREAKER_FAIL_O == (|FAILURE_TIMER_OUT_O))
      else $error("Breaker fail differs from timer outputs");
   chk_pend_needs_run:
   assert property ($rose(PENDING_TIMER_OUT_O[0]) |-> TIMER_RUN_O[0])
      else $error("Pending timer expired without run");
   chk_idle_clears:
   assert property (!TIMER_RUN_O[0] [*3] |->
      !PENDING_TIMER_OUT_O[0] && !FAILURE_TIMER_OUT_O[0])
      else $error("Timer output held while idle");
   chk_no_load_stop:
   assert property (idle_cnt >= 8'(3 * QCYC_CLKS) |-> !TIMER_RUN_O[0])
      else $error("Run held without load current");
   chk_off_blocks:
   assert property ((CFG_I.scheme == bfd_pkg::BFD_OFF) [*3] |->
      TIMER_RUN_O == 3'h0)
      else $error("Run while protection off");
   chk_trip_blocks:
   assert property ((|(LOGIC_BITS_I & MAP_I.trip_in[0])) [*6] |->
      !TIMER_RUN_O[0])
      else $error("Run during trip input");
   chk_close_blocks:
   assert property ((|(LOGIC_BITS_I & (MAP_I.auto_close_in
      | MAP_I.manual_close_in))) [*6] |-> TIMER_RUN_O == 3'h0)
      else $error("Run during close input");
   cov_pend: cover property ($rose(FLASH_PENDING_ALARM_O));
   cov_fail: cover property ($rose(FLASH_BREAKER_FAIL_O));
   cov_stop: cover property ($fell(TIMER_RUN_O[0]));
endmodule : bfd_checker

bind bfd_detector bfd_checker #(.QCYC_CLKS(QCYC_CLKS)) chk_u (
   .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .CFG_I(CFG_I),
   .MAP_I(MAP_I), .LOGIC_BITS_I(LOGIC_BITS_I), .MEAS_I(MEAS_I),
   .PENDING_TIMER_OUT_O(PENDING_TIMER_OUT_O),
   .FAILURE_TIMER_OUT_O(FAILURE_TIMER_OUT_O),
   .TIMER_RUN_O(TIMER_RUN_O), .FLASH_PENDING_ALARM_O(FLASH_PENDING_ALARM_O),
   .FLASH_BREAKER_FAIL_O(FLASH_BREAKER_FAIL_O));

// >>> dv/bfd_detector_test.sv
// Self-checking bench for the breaker flashover detector
module bfd_detector_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned QC = 4;
   logic                     sys_clk = 1'b0;
   logic                     rst_n = 1'b0;
   bfd_pkg::bfd_cfg_t        cfg;
   bfd_pkg::bfd_map_t        map;
   bfd_pkg::bfd_meas_t [2:0] meas;
   logic [15:0]              bits;
   logic [2:0]               pole = 3'h7;
   logic [2:0]               trip = 3'h0;
   logic [1:0]               clo = 2'h0;
   logic [2:0]               pto, fto, run;
   logic                     pa, bf;
   logic [2:0]               mon;
   int                       mismatches = 0;
   int                       check_count = 0;
   always #50 sys_clk = ~sys_clk;
   assign mon = {fto[0], pto[0], run[0]};
   bfd_breaker_model brk_u (.clk_i(sys_clk), .pole_closed_i(pole),
      .trip_i(trip), .close_i(clo), .bits_o(bits));
   bfd_detector #(.QCYC_CLKS(QC)) dut_u (.SYS_CLK_I(sys_clk),
      .RST_N_I(rst_n), .CFG_I(cfg), .MAP_I(map), .LOGIC_BITS_I(bits),
      .MEAS_I(meas), .PENDING_TIMER_OUT_O(pto), .FAILURE_TIMER_OUT_O(fto),
      .TIMER_RUN_O(run), .FLASH_PENDING_ALARM_O(pa),
      .FLASH_BREAKER_FAIL_O(bf));
   task automatic check(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      $display("Checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   // Bounded wait on run, pending or failure output of phase A
   task automatic wait_on(input int sel, input logic exp, output int n);
      n = 0;
      while (mon[sel] !== exp) begin
         @(negedge sys_clk);
         n++;
         if (n > 200) begin
            check("wait bound", 16'h0001, 16'h0000);
            end_of_test;
         end
      end
   endtask : wait_on
   task automatic quiet(input string nm);
      logic any;
      any = 1'b0;
      repeat (40) begin
         @(negedge sys_clk);
         any |= run[0];
      end
      check(nm, 16'(any), 16'h0000);
   endtask : quiet
   task automatic settle;
      int n;
      meas = '0;
      wait_on(0, 1'b0, n);
      repeat (12) @(negedge sys_clk);
   endtask : settle
   // Live side sampled with no load, then the open pole carries current
   task automatic flash2;
      int n;
      pole = 3'h6;
      meas[0] = '{12'h000, 12'h29E, 13'h0000};
      repeat (12) @(negedge sys_clk);
      meas[0].current = 13'h0064;
      wait_on(0, 1'b1, n);
   endtask : flash2
   task automatic t_scheme2;
      int n;
      cfg.scheme = bfd_pkg::BFD_SCHEME2;
      pole = 3'h6;
      meas[0] = '{12'h000, 12'h000, 13'h0064};
      quiet("dead side");
      settle;
      flash2;
      // Run and timer outputs share one register stage, so the gap is exact
      wait_on(1, 1'b1, n);
      check("pend time", 16'(n), 16'(4 * QC));
      wait_on(2, 1'b1, n);
      check("fail gap", 16'(n), 16'((8 - 4) * QC));
      check("outputs", {8'h00, pa, bf, pto, fto}, 16'h00C9);
      meas[0].current = 13'h0000;
      wait_on(0, 1'b0, n);
      check("stop time", 16'(n <= 12), 16'h1);
      repeat (3) @(negedge sys_clk);
      check("cleared", {14'h0, pa, bf}, 16'h0000);
      settle;
      $display("t_scheme2 done");
   endtask : t_scheme2
   task automatic t_stops;
      int n;
      cfg.scheme = bfd_pkg::BFD_SCHEME2;
      for (int k = 0; k < 4; k++) begin
         flash2;
         trip = (k == 0) ? 3'h1 : 3'h0;
         clo = (k == 1) ? 2'h1 : (k == 2) ? 2'h2 : 2'h0;
         if (k == 3) pole = 3'h7;
         wait_on(0, 1'b0, n);
         check("stopped", 16'(n <= 12), 16'h1);
         // Hold the stop long enough for the checker's six-sample window
         repeat (8) @(negedge sys_clk);
         check("held off", {15'h0, run[0]}, 16'h0000);
         trip = 3'h0;
         clo = 2'h0;
         settle;
      end
      $display("t_stops done");
   endtask : t_stops
   task automatic t_scheme1;
      int n;
      bfd_pkg::bfd_scheme_t sc [3] = '{bfd_pkg::BFD_SCHEME1,
         bfd_pkg::BFD_CUSTOM, bfd_pkg::BFD_OFF};
      pole = 3'h7;
      cfg.scheme = bfd_pkg::BFD_SCHEME1;
      meas[0] = '{12'h014, 12'h000, 13'h0064};
      quiet("no prior diff");
      settle;
      for (int k = 0; k < 3; k++) begin
         cfg.scheme = sc[k];
         meas[0] = '{12'h29E, 12'h000, 13'h0000};
         repeat (12) @(negedge sys_clk);
         meas[0] = '{12'h014, 12'h000, 13'h0064};
         if (k < 2) wait_on(0, 1'b1, n);
         else quiet("off");
         settle;
      end
      $display("t_scheme1 done");
   endtask : t_scheme1
   initial begin
      // Pending delay kept shorter than failure delay
      cfg = '{bfd_pkg::BFD_OFF, 12'h23A, 12'h028, 12'h02B, 12'h23A,
         13'h000A, 16'h0004, 16'h0008};
      map = '0;
      for (int p = 0; p < 3; p++) begin
         map.trip_in[p] = 16'h0008 << p;
         map.status[p] = 16'h0001 << p;
      end
      map.auto_close_in = 16'h0040;
      map.manual_close_in = 16'h0080;
      meas = '0;
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      t_scheme2;
      t_stops;
      t_scheme1;
      end_of_test;
   end
endmodule : bfd_detector_test
